/* File: hw/tgmc_misc_regs.sv */
// miscellaneous control registers and standby output gating of the timing generator
`default_nettype none
module tgmc_misc_regs
    import tgmc_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // serial register port
    input  wire logic        serClk,
    input  wire logic        serData,
    input  wire logic        serLoadN,
    // timing core state
    input  wire logic [1:0]  standbyState,
    input  wire logic        output_gate_input,
    input  wire logic [2:0]  fieldCount,
    input  wire logic        fieldStart,
    // internal timing signals
    input  wire logic        substrateClockInt,
    input  wire logic        bias_sig_zero,
    input  wire logic        bias_sig_one,
    input  wire logic        shutter_sig_zero,
    input  wire logic        shutter_sig_one,
    input  wire logic        shutter_sig_two,
    input  wire logic        flashInt,
    // outputs
    output logic             substrate_clock_out,
    output logic [1:0]       substrate_bias_out,
    output logic             mech_shutter_out,
    output logic             flashOut,
    output logic             field_pulse_out,
    output logic             sweep_extend_bit,
    output logic [9:0]       startup_setting,
    output logic [11:0]      test_field_a,
    output logic             test_bit_b
);
    logic                   wrStrobe;
    logic [11:0]            wrAddr;
    logic [27:0]            wrData;
    logic [STBY3_POL_W-1:0] stbyPol_r;
    logic [MUX_CTRL_W-1:0]  muxCtrl_r;
    logic [FIELD_CTL_W-1:0] fieldCtl_r;
    logic                   holdOutputs;
    logic                   bias0Nxt;
    logic                   bias1Nxt;
    logic                   shutNxt;

    tgmc_serial_rx u_rx (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .serClk   (serClk),
        .serData  (serData),
        .serLoadN (serLoadN),
        .wrStrobe (wrStrobe),
        .wrAddr   (wrAddr),
        .wrData   (wrData)
    );

    // register writes land the cycle after the frame's last bit
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            stbyPol_r        <= STBY3_POL_RST;
            sweep_extend_bit <= SWEEP_RST;
            startup_setting  <= STARTUP_RST;
            muxCtrl_r        <= MUX_CTRL_RST;
            fieldCtl_r       <= FIELD_CTL_RST;
        end else if (wrStrobe) begin
            unique case (wrAddr)
                ADDR_STBY3_POL:   stbyPol_r        <= wrData[STBY3_POL_W-1:0];
                ADDR_SWEEP_CTRL:  sweep_extend_bit <= wrData[0];
                // host is expected to load the start-up value here
                ADDR_STARTUP:     startup_setting  <= wrData[STARTUP_W-1:0];
                ADDR_MUX_CTRL:    muxCtrl_r        <= wrData[MUX_CTRL_W-1:0];
                ADDR_FIELD_PULSE: fieldCtl_r       <= wrData[FIELD_CTL_W-1:0];
                default: begin
                    // other addresses belong to other blocks
                end
            endcase
        end
    end

    // test bits only exposed, host keeps bit 14 clear
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            test_field_a <= MUX_CTRL_RST[TEST_A_MSB:TEST_A_LSB];
            test_bit_b   <= MUX_CTRL_RST[TEST_B_BIT];
        end else begin
            test_field_a <= muxCtrl_r[TEST_A_MSB:TEST_A_LSB];
            test_bit_b   <= muxCtrl_r[TEST_B_BIT];
        end
    end

    assign holdOutputs = (standbyState != STBY_NONE) || !output_gate_input;

    assign bias0Nxt = muxCtrl_r[BIAS0_SEL_BIT] ? (shutter_sig_zero ^ bias_sig_zero)
                                               : bias_sig_zero;
    assign bias1Nxt = muxCtrl_r[BIAS1_SEL_BIT] ? (shutter_sig_zero ^ bias_sig_one)
                                               : bias_sig_one;
    assign shutNxt  = muxCtrl_r[SHUT_COMBO_BIT] ? (shutter_sig_zero ^ shutter_sig_two)
                                                : (shutter_sig_zero ^ shutter_sig_one);

    // one register stage on every output keeps the pins glitch free
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            substrate_clock_out <= 1'b0;
            substrate_bias_out  <= 2'h0;
            mech_shutter_out    <= 1'b0;
            flashOut            <= 1'b0;
        end else if (holdOutputs) begin
            substrate_clock_out <= stbyPol_r[POL_SUBCK_BIT];
            substrate_bias_out  <= {2{stbyPol_r[POL_BIAS_BIT]}};
            mech_shutter_out    <= stbyPol_r[POL_SHUT_BIT];
            flashOut            <= stbyPol_r[POL_FLASH_BIT];
        end else begin
            substrate_clock_out <= substrateClockInt;
            substrate_bias_out  <= {bias1Nxt, bias0Nxt};
            mech_shutter_out    <= shutNxt;
            flashOut            <= flashInt;
        end
    end

    // field pulse: one cycle at the start of the selected field
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            field_pulse_out <= 1'b0;
        end else begin
            field_pulse_out <= fieldCtl_r[FIELD_EN_BIT] && fieldStart
                && (fieldCount == fieldCtl_r[FIELD_SEL_MSB:FIELD_SEL_LSB]);
        end
    end
endmodule // tgmc_misc_regs
`default_nettype wire

/* File: hw/tgmc_pkg.sv */
// constants for the timing generator miscellaneous control registers
`default_nettype none
package tgmc_pkg;
    // serial frame layout: address first, then data, both lsb first
    localparam int unsigned ADDR_BITS = 12;
    localparam int unsigned DATA_BITS = 28;
    localparam int unsigned FRAME_BITS = ADDR_BITS + DATA_BITS;

    // register addresses
    localparam logic [11:0] ADDR_SWEEP_CTRL  = 12'h0e6;
    localparam logic [11:0] ADDR_STARTUP     = 12'h0ea;
    localparam logic [11:0] ADDR_MUX_CTRL    = 12'h0eb;
    localparam logic [11:0] ADDR_FIELD_PULSE = 12'h0f1;
    localparam logic [11:0] ADDR_STBY3_POL   = 12'h0f4;

    // register widths
    localparam int unsigned STBY3_POL_W = 25;
    localparam int unsigned STARTUP_W   = 10;
    localparam int unsigned MUX_CTRL_W  = 16;
    localparam int unsigned FIELD_CTL_W = 4;

    // reset values
    localparam logic [24:0] STBY3_POL_RST = 25'h0000000;
    localparam logic        SWEEP_RST     = 1'h0;
    localparam logic [9:0]  STARTUP_RST   = 10'h000;
    localparam logic [15:0] MUX_CTRL_RST  = 16'h0300;
    localparam logic [3:0]  FIELD_CTL_RST = 4'h0;

    // standby polarity word fields
    localparam int unsigned POL_SUBCK_BIT = 21;
    localparam int unsigned POL_BIAS_BIT  = 22;
    localparam int unsigned POL_SHUT_BIT  = 23;
    localparam int unsigned POL_FLASH_BIT = 24;

    // mux control fields
    localparam int unsigned TEST_A_LSB     = 0;
    localparam int unsigned TEST_A_MSB     = 11;
    localparam int unsigned BIAS0_SEL_BIT  = 12;
    localparam int unsigned BIAS1_SEL_BIT  = 13;
    localparam int unsigned TEST_B_BIT     = 14;
    localparam int unsigned SHUT_COMBO_BIT = 15;

    // field pulse control fields
    localparam int unsigned FIELD_SEL_LSB = 0;
    localparam int unsigned FIELD_SEL_MSB = 2;
    localparam int unsigned FIELD_EN_BIT  = 3;

    // standby state codes
    localparam logic [1:0] STBY_NONE = 2'h0;

    typedef enum logic [1:0] {
        TGMC_IDLE = 2'b00,
        TGMC_ADDR = 2'b01,
        TGMC_DATA = 2'b11
    } tgmc_ser_state_t;
endpackage
`default_nettype wire

/* File: hw/tgmc_serial_rx.sv */
// 3-wire serial write receiver, sampled on the system clock
`default_nettype none
module tgmc_serial_rx
    import tgmc_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // serial pins
    input  wire logic        serClk,
    input  wire logic        serData,
    input  wire logic        serLoadN,
    // decoded write
    output logic             wrStrobe,
    output logic [11:0]      wrAddr,
    output logic [27:0]      wrData
);
    tgmc_ser_state_t state_r;
    logic            serClkPrev_r;
    logic [5:0]      bitCnt_r;
    logic [39:0]     shift_r;
    logic            rise;
    logic [39:0]     shiftNxt;

    assign rise     = serClk && !serClkPrev_r && !serLoadN;
    assign shiftNxt = {serData, shift_r[39:1]};

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            serClkPrev_r <= 1'b0;
        end else begin
            serClkPrev_r <= serClk;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_r  <= TGMC_IDLE;
            bitCnt_r <= 6'h00;
            shift_r  <= 40'h0000000000;
            wrStrobe <= 1'b0;
            wrAddr   <= 12'h000;
            wrData   <= 28'h0000000;
        end else begin
            wrStrobe <= 1'b0;
            if (serLoadN) begin
                // frame aborted or ended: partial words are dropped
                state_r  <= TGMC_IDLE;
                bitCnt_r <= 6'h00;
            end else if (rise) begin
                shift_r <= shiftNxt;
                unique case (state_r)
                    TGMC_IDLE: begin
                        state_r  <= TGMC_ADDR;
                        bitCnt_r <= 6'h01;
                    end
                    TGMC_ADDR: begin
                        bitCnt_r <= bitCnt_r + 6'h01;
                        if (bitCnt_r == 6'(ADDR_BITS - 1)) begin
                            state_r <= TGMC_DATA;
                        end
                    end
                    TGMC_DATA: begin
                        if (bitCnt_r == 6'(FRAME_BITS - 1)) begin
                            wrStrobe <= 1'b1;
                            wrAddr   <= shiftNxt[11:0];
                            wrData   <= shiftNxt[39:12];
                            state_r  <= TGMC_IDLE;
                            bitCnt_r <= 6'h00;
                        end else begin
                            bitCnt_r <= bitCnt_r + 6'h01;
                        end
                    end
                    default: begin
                        state_r <= TGMC_IDLE;
                    end
                endcase
            end
        end
    end
endmodule // tgmc_serial_rx
`default_nettype wire

/* File: tb/tgmc_misc_regs_asserts.sv */
// port-level checks for the misc control register block
`default_nettype none
module tgmc_misc_regs_asserts (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    // serial and timing inputs
    input wire logic        serLoadN,
    input wire logic [1:0]  standbyState,
    input wire logic        output_gate_input,
    input wire logic        fieldStart,
    input wire logic        substrateClockInt,
    input wire logic        bias_sig_zero,
    input wire logic        shutter_sig_zero,
    input wire logic        shutter_sig_one,
    input wire logic        shutter_sig_two,
    input wire logic        flashInt,
    // outputs
    input wire logic        substrate_clock_out,
    input wire logic [1:0]  substrate_bias_out,
    input wire logic        mech_shutter_out,
    input wire logic        flashOut,
    input wire logic        field_pulse_out,
    input wire logic        sweep_extend_bit,
    input wire logic [11:0] test_field_a
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic norm;
    assign norm = standbyState == 2'h0 && output_gate_input;
    // first edge after release still sees the reset values on the outputs, hence the guard
    property p_subck;
        !$past(sys_rst) && $past(norm) |-> substrate_clock_out == $past(substrateClockInt);
    endproperty
    a_subck: assert property (p_subck) else $error("substrate clock off its source");
    property p_flash;
        !$past(sys_rst) && $past(norm) |-> flashOut == $past(flashInt);
    endproperty
    a_flash: assert property (p_flash) else $error("flash output off its source");
    property p_bias_stby;
        !$past(sys_rst) && !$past(norm) |-> substrate_bias_out[0] == substrate_bias_out[1];
    endproperty
    a_bias_stby: assert property (p_bias_stby) else $error("bias pair split in standby");
    property p_shut;
        !$past(sys_rst) && $past(norm)
            |-> mech_shutter_out == $past(shutter_sig_zero ^ shutter_sig_one)
            || mech_shutter_out == $past(shutter_sig_zero ^ shutter_sig_two);
    endproperty
    a_shut: assert property (p_shut) else $error("shutter output not a legal combination");
    property p_bias0;
        !$past(sys_rst) && $past(norm)
            |-> substrate_bias_out[0] == $past(bias_sig_zero)
            || substrate_bias_out[0] == $past(shutter_sig_zero ^ bias_sig_zero);
    endproperty
    a_bias0: assert property (p_bias0) else $error("bias output 0 not a legal choice");
    property p_pulse;
        field_pulse_out |-> $past(fieldStart) && !$past(field_pulse_out);
    endproperty
    a_pulse: assert property (p_pulse) else $error("field pulse without field start");
    // last bit taken at edge n, register at n+1, seen changed at n+2
    property p_sweep;
        $changed(sweep_extend_bit) |-> !$past(serLoadN, 2);
    endproperty
    a_sweep: assert property (p_sweep) else $error("sweep bit moved outside a frame");
    // registered copy adds one more stage behind the register
    property p_testa;
        $changed(test_field_a) |-> !$past(serLoadN, 3);
    endproperty
    a_testa: assert property (p_testa) else $error("test field moved outside a frame");
endmodule // tgmc_misc_regs_asserts
bind tgmc_misc_regs tgmc_misc_regs_asserts u_tgmc_misc_regs_asserts (.*);
`default_nettype wire

/* File: tb/tgmc_misc_regs_tb_top.sv */
// self-checking bench for the misc control register block
`default_nettype none
module tgmc_misc_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import tgmc_pkg::*;
    typedef struct packed {
        logic [15:0] mux;
        logic [24:0] pol;
        logic [1:0]  stby;
        logic        gate;
        logic [6:0]  src;
        logic [4:0]  exp;
    } tgmc_row_t;
    // src: subck, bias0, bias1, shutter_sig_zero, shutter_sig_one, shutter_sig_two, flash; exp: subck, bias[1:0], shut, flash
    localparam tgmc_row_t ROWS [6] = '{
        '{16'h0300, 25'h0000000, 2'h0, 1'b1, 7'h6b, 5'h17},
        '{16'hb300, 25'h0000000, 2'h0, 1'b1, 7'h6b, 5'h19},
        '{16'h0300, 25'h1e00000, 2'h1, 1'b1, 7'h00, 5'h1f},
        '{16'h0300, 25'h0400000, 2'h3, 1'b1, 7'h7f, 5'h0c},
        '{16'h0300, 25'h1200000, 2'h0, 1'b0, 7'h3f, 5'h11},
        '{16'hb300, 25'h0a00000, 2'h2, 1'b1, 7'h00, 5'h12}};
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic        serClk = 1'b0;
    logic        serData = 1'b0;
    logic        serLoadN = 1'b1;
    logic [1:0]  standbyState = 2'h0;
    logic        outGate = 1'b1;
    logic [2:0]  fieldCount = 3'h0;
    logic        fieldStart = 1'b0;
    logic [6:0]  src = 7'h00;
    logic        subck, shut, flash, pulse, sweep, testB;
    logic [1:0]  bias;
    logic [9:0]  startup;
    logic [11:0] testA;
    int          miscompares = 0;
    int          n_tests = 0;
    always #12.5 clk_sys = ~clk_sys;
    tgmc_misc_regs u_tgmc_misc_regs (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .serClk(serClk), .serData(serData),
        .serLoadN(serLoadN), .standbyState(standbyState), .output_gate_input(outGate),
        .fieldCount(fieldCount), .fieldStart(fieldStart), .substrateClockInt(src[6]),
        .bias_sig_zero(src[5]), .bias_sig_one(src[4]), .shutter_sig_zero(src[3]),
        .shutter_sig_one(src[2]), .shutter_sig_two(src[1]), .flashInt(src[0]),
        .substrate_clock_out(subck), .substrate_bias_out(bias), .mech_shutter_out(shut),
        .flashOut(flash), .field_pulse_out(pulse), .sweep_extend_bit(sweep),
        .startup_setting(startup), .test_field_a(testA), .test_bit_b(testB));
    task automatic chk(input string name, input logic [27:0] seen, input logic [27:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // n below 40 drops the select early to abort the frame
    task automatic frame(input logic [11:0] a, input logic [27:0] d, input int n);
        logic [39:0] bits;
        bits = {d, a};
        @(negedge clk_sys) serLoadN = 1'b0;
        for (int i = 0; i < n; i++) begin
            serData = bits[i];
            serClk = 1'b0;
            @(negedge clk_sys) serClk = 1'b1;
            @(negedge clk_sys);
        end
        serClk = 1'b0;
        serLoadN = 1'b1;
        repeat (3) @(negedge clk_sys);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #200us;
        miscompares++;
        tally_and_finish();
    end
    initial begin
        repeat (4) @(negedge clk_sys);
        sys_rst = 1'b0;
        chk("sweep", 28'(sweep), 28'h0);
        chk("startup", 28'(startup), 28'h0);
        chk("testA", 28'(testA), 28'h300);
        chk("testB", 28'(testB), 28'h0);
        foreach (ROWS[i]) begin
            frame(ADDR_MUX_CTRL, 28'(ROWS[i].mux), 40);
            frame(ADDR_STBY3_POL, 28'(ROWS[i].pol), 40);
            standbyState = ROWS[i].stby;
            outGate = ROWS[i].gate;
            src = ROWS[i].src;
            repeat (2) @(negedge clk_sys);
            chk("outs", 28'({subck, bias, shut, flash}), 28'(ROWS[i].exp));
        end
        standbyState = 2'h0;
        frame(ADDR_SWEEP_CTRL, 28'h1, 40);
        chk("sweep", 28'(sweep), 28'h1);
        frame(12'h0e7, 28'h0, 40);
        frame(ADDR_SWEEP_CTRL, 28'h0, 20);
        chk("sweep", 28'(sweep), 28'h1);
        frame(ADDR_SWEEP_CTRL, 28'h0, 40);
        chk("sweep", 28'(sweep), 28'h0);
        frame(ADDR_STARTUP, 28'h60, 40);
        chk("startup", 28'(startup), 28'h60);
        frame(ADDR_MUX_CTRL, 28'h4abc, 40);
        chk("testA", 28'(testA), 28'habc);
        chk("testB", 28'(testB), 28'h1);
        frame(ADDR_MUX_CTRL, 28'(MUX_CTRL_RST), 40);
        fieldStart = 1'b1;
        @(negedge clk_sys) fieldStart = 1'b0;
        chk("pulse", 28'(pulse), 28'h0);
        for (int s = 0; s < 8; s++) begin
            frame(ADDR_FIELD_PULSE, 28'(8 + s), 40);
            for (int k = 0; k < 2; k++) begin
                fieldCount = 3'(s + k);
                fieldStart = 1'b1;
                @(negedge clk_sys) fieldStart = 1'b0;
                chk("pulse", 28'(pulse), 28'(k == 0));
                @(negedge clk_sys);
            end
        end
        // mid-run reset must clear outputs and return registers to their reset values
        src = 7'h7f;
        repeat (2) @(negedge clk_sys);
        sys_rst = 1'b1;
        @(negedge clk_sys);
        chk("outs", 28'({subck, bias, shut, flash}), 28'h0);
        chk("startup", 28'(startup), 28'h0);
        @(negedge clk_sys) sys_rst = 1'b0;
        repeat (2) @(negedge clk_sys);
        chk("outs", 28'({subck, bias, shut, flash}), 28'h1d);
        chk("sweep", 28'(sweep), 28'h0);
        chk("testA", 28'(testA), 28'h300);
        // field control held enable and select 7 before reset
        fieldCount = 3'h7;
        fieldStart = 1'b1;
        @(negedge clk_sys) fieldStart = 1'b0;
        chk("pulse", 28'(pulse), 28'h0);
        tally_and_finish();
    end
endmodule // tgmc_misc_regs_tb_top
`default_nettype wire
